// ===== core/prioritizer_pkg.sv
package prioritizer_pkg;

   localparam int source_count = 64;
   localparam int index_width = 6;
   localparam int level_width = 4;
   localparam int level_reg_count = 8;
   localparam int sources_per_level_reg = 8;
   localparam int word_width = 32;
   localparam int mask_width = 5;

   // Mask value all ones reads as minus one: nothing masked
   localparam logic [mask_width-1:0] mask_reset = 5'h1f;
   localparam logic [source_count-1:0] enable_reset = 64'h0;
   localparam logic [source_count-1:0] type_reset = 64'h0;
   localparam logic [word_width-1:0] level_reset = 32'h0;

   // Read selects carried in the index field of a read command
   localparam logic [index_width-1:0] sel_enable_lo = 6'h00;
   localparam logic [index_width-1:0] sel_enable_hi = 6'h01;
   localparam logic [index_width-1:0] sel_type_lo = 6'h02;
   localparam logic [index_width-1:0] sel_type_hi = 6'h03;
   localparam logic [index_width-1:0] sel_level_base = 6'h04;
   localparam logic [index_width-1:0] sel_mask = 6'h0c;
   localparam logic [index_width-1:0] sel_pending_lo = 6'h0d;
   localparam logic [index_width-1:0] sel_pending_hi = 6'h0e;

   typedef enum logic [3:0] {
      op_none = 4'h0,
      op_enable_lo = 4'h1,
      op_enable_hi = 4'h2,
      op_enable_num = 4'h3,
      op_disable_num = 4'h4,
      op_type_lo = 4'h5,
      op_type_hi = 4'h6,
      op_level = 4'h7,
      op_mask = 4'h8,
      op_read = 4'h9
   } cfg_op_type;

   typedef struct packed {
      logic valid;
      logic supervisor;
      cfg_op_type op;
      logic [index_width-1:0] index;
      logic [word_width-1:0] data;
   } cfg_cmd_type;

   typedef struct packed {
      logic active;
      logic [index_width-1:0] vector;
      logic [level_width-1:0] level;
   } irq_req_type;

endpackage

// ===== core/source_sync.sv
`timescale 1ns/100ps
module source_sync
   import prioritizer_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [source_count-1:0] i_async,
   output logic [source_count-1:0] o_sync
);
   logic [source_count-1:0] first_reg;
   logic [source_count-1:0] second_reg;
   logic [source_count-1:0] first_next;
   logic [source_count-1:0] second_next;

   always_comb begin
      first_next = i_async;
      second_next = first_reg;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         first_reg <= '0;
         second_reg <= '0;
      end else begin
         first_reg <= first_next;
         second_reg <= second_next;
      end
   end

   assign o_sync = second_reg;
endmodule

// ===== core/vectored_interrupt_prioritizer.sv
// Operation
// (R1) Accept and arbitrate up to 64 internal and external interrupt source lines.
// (R2) Per-source enable, set by vector write or by enable/disable source number.
// (R3) Enabled asserted source raises normal or fast request per its type bit.
// (R4) Register reads and writes take effect only for supervisor-mode accesses.
// (R5) Fast requests beat all normal ones; normals ranked by highest level.
// (R6) Equal highest normal levels: highest source number wins.
// (R7) Each source has a normal level of sixteen values, zero lowest.
// (R8) Levels are programmable, held in eight level registers covering all sources.
// (R9) A normal mask register suppresses normal requests by priority level.
// (R10) Normal level at or below mask is blocked; fast requests unaffected.
`timescale 1ns/100ps
module vectored_interrupt_prioritizer
   import prioritizer_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [source_count-1:0] i_sources,
   input wire cfg_cmd_type i_cfg,
   output irq_req_type o_normal,
   output irq_req_type o_fast,
   output irq_req_type o_active,
   output logic o_active_fast,
   output logic [word_width-1:0] o_read_data,
   output logic o_read_valid,
   output logic o_access_denied
);
   logic [source_count-1:0] src_sync;
   logic [source_count-1:0] enable_reg, enable_next;
   logic [source_count-1:0] type_reg, type_next;
   logic [word_width-1:0] level_reg [level_reg_count];
   logic [word_width-1:0] level_next [level_reg_count];
   logic [mask_width-1:0] mask_reg, mask_next;
   irq_req_type normal_reg, normal_next;
   irq_req_type fast_reg, fast_next;
   irq_req_type active_reg, active_next;
   logic active_fast_reg, active_fast_next;
   logic [word_width-1:0] read_data_reg, read_data_next;
   logic read_valid_reg, read_valid_next;
   logic denied_reg, denied_next;
   logic [source_count-1:0] pending;
   logic granted;

   function automatic logic [level_width-1:0] level_of(input logic [index_width-1:0] idx);
      logic [word_width-1:0] word;
      word = level_reg[idx[index_width-1:3]];
      return word[idx[2:0]*level_width +: level_width];
   endfunction

   // Signed compare so the all-ones mask blocks nothing
   function automatic logic above_mask(input logic [level_width-1:0] lvl,
                                       input logic [mask_width-1:0] msk);
      return $signed({1'b0, lvl}) > $signed(msk);
   endfunction

   // (R1) sync all lines
   source_sync sync_inst (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_sources),
      .o_sync(src_sync)
   );

   assign pending = src_sync & enable_reg;
   // (R4) supervisor gate
   assign granted = i_cfg.valid && i_cfg.supervisor;

   always_comb begin
      enable_next = enable_reg;
      type_next = type_reg;
      mask_next = mask_reg;
      for (int r = 0; r < level_reg_count; r++) begin
         level_next[r] = level_reg[r];
      end
      read_data_next = '0;
      read_valid_next = 1'b0;
      denied_next = i_cfg.valid && !i_cfg.supervisor;
      if (granted) begin
         unique case (i_cfg.op)
            // (R2) enable vector write
            op_enable_lo: enable_next[31:0] = i_cfg.data;
            op_enable_hi: enable_next[63:32] = i_cfg.data;
            // (R2) enable by number
            op_enable_num: enable_next[i_cfg.index] = 1'b1;
            // (R2) disable by number
            op_disable_num: enable_next[i_cfg.index] = 1'b0;
            op_type_lo: type_next[31:0] = i_cfg.data;
            op_type_hi: type_next[63:32] = i_cfg.data;
            // (R8) level register write
            op_level: level_next[i_cfg.index[2:0]] = i_cfg.data;
            // (R9) mask write
            op_mask: mask_next = i_cfg.data[mask_width-1:0];
            op_read: begin
               read_valid_next = 1'b1;
               if (i_cfg.index == sel_enable_lo) begin
                  read_data_next = enable_reg[31:0];
               end else if (i_cfg.index == sel_enable_hi) begin
                  read_data_next = enable_reg[63:32];
               end else if (i_cfg.index == sel_type_lo) begin
                  read_data_next = type_reg[31:0];
               end else if (i_cfg.index == sel_type_hi) begin
                  read_data_next = type_reg[63:32];
               end else if (i_cfg.index >= sel_level_base && i_cfg.index < sel_mask) begin
                  read_data_next = level_reg[3'(i_cfg.index - sel_level_base)];
               end else if (i_cfg.index == sel_mask) begin
                  read_data_next = {27'h0, mask_reg};
               end else if (i_cfg.index == sel_pending_lo) begin
                  read_data_next = pending[31:0];
               end else if (i_cfg.index == sel_pending_hi) begin
                  read_data_next = pending[63:32];
               end
            end
            op_none: begin
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         enable_reg <= enable_reset;
         type_reg <= type_reset;
         mask_reg <= mask_reset;
         for (int r = 0; r < level_reg_count; r++) begin
            level_reg[r] <= level_reset;
         end
         read_data_reg <= '0;
         read_valid_reg <= 1'b0;
         denied_reg <= 1'b0;
      end else begin
         enable_reg <= enable_next;
         type_reg <= type_next;
         mask_reg <= mask_next;
         for (int r = 0; r < level_reg_count; r++) begin
            level_reg[r] <= level_next[r];
         end
         read_data_reg <= read_data_next;
         read_valid_reg <= read_valid_next;
         denied_reg <= denied_next;
      end
   end

   // Arbitration: flat scan, one pass; timing traded for area
   always_comb begin
      logic [level_width-1:0] lvl;
      lvl = '0;
      normal_next = '0;
      fast_next = '0;
      for (int i = 0; i < source_count; i++) begin
         lvl = level_of(6'(i));
         // (R3) fast per type bit
         if (pending[i] && type_reg[i]) begin
            fast_next.active = 1'b1;
            fast_next.vector = 6'(i);
         end
         // (R6) ties go to higher number
         // (R7) (R10) level above mask only
         if (pending[i] && !type_reg[i] && above_mask(lvl, mask_reg) &&
             (!normal_next.active || lvl >= normal_next.level)) begin
            normal_next.active = 1'b1;
            normal_next.vector = 6'(i);
            normal_next.level = lvl;
         end
      end
      // (R5) fast ahead of normal
      active_fast_next = fast_next.active;
      active_next = fast_next.active ? fast_next : normal_next;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         normal_reg <= '0;
         fast_reg <= '0;
         active_reg <= '0;
         active_fast_reg <= 1'b0;
      end else begin
         normal_reg <= normal_next;
         fast_reg <= fast_next;
         active_reg <= active_next;
         active_fast_reg <= active_fast_next;
      end
   end

   assign o_normal = normal_reg;
   assign o_fast = fast_reg;
   assign o_active = active_reg;
   assign o_active_fast = active_fast_reg;
   assign o_read_data = read_data_reg;
   assign o_read_valid = read_valid_reg;
   assign o_access_denied = denied_reg;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_enable_by_num: assert property ( // (R2)
      granted && i_cfg.op == op_enable_num |=> enable_reg[$past(i_cfg.index)])
      else $error("enable by number not applied");
   a_disable_by_num: assert property ( // (R2)
      granted && i_cfg.op == op_disable_num |=> !enable_reg[$past(i_cfg.index)])
      else $error("disable by number not applied");
   a_user_mode_ignored: assert property ( // (R4)
      i_cfg.valid && !i_cfg.supervisor |=> $stable(enable_reg) && $stable(type_reg)
         && $stable(mask_reg) && o_access_denied && !o_read_valid)
      else $error("user mode access changed state");
   a_fast_raised: assert property ( // (R3)
      |(pending & type_reg) |=> o_fast.active)
      else $error("fast request missing");
   a_fast_wins: assert property ( // (R5)
      o_fast.active |-> o_active_fast && o_active.vector == o_fast.vector)
      else $error("fast request not preferred");
   a_normal_above_mask: assert property ( // (R10)
      o_normal.active |-> $signed({1'b0, o_normal.level}) > $signed($past(mask_reg)))
      else $error("masked normal level raised");
   a_idle_no_request: assert property ( // (R3)
      pending == '0 |=> !o_normal.active && !o_fast.active)
      else $error("request without pending source");
   a_level_write: assert property ( // (R8)
      granted && i_cfg.op == op_level |=> level_reg[$past(i_cfg.index[2:0])]
         == $past(i_cfg.data))
      else $error("level register not written");
   // Top level on the top source must win any tie
   a_top_source_wins: assert property ( // (R6)
      pending[63] && !type_reg[63] && level_reg[7][31:28] == 4'hf
         && above_mask(4'hf, mask_reg) |=> o_normal.vector == 6'h3f)
      else $error("highest number lost a tie");

   c_fast_request: cover property (o_fast.active);
   c_both_pending: cover property (o_fast.active && o_normal.active);
   c_normal_masked: cover property (|(pending & ~type_reg) && !normal_next.active);
   c_denied: cover property (o_access_denied);
endmodule

// ===== bench/core_model.sv
`timescale 1ns/100ps
module core_model
   import prioritizer_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire irq_req_type i_normal,
   input wire irq_req_type i_fast,
   output logic [index_width-1:0] o_vector,
   output logic o_in_fast
);
   // Core takes fast entry before normal, as its exception model does
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_vector <= '0;
         o_in_fast <= 1'b0;
      end else if (i_fast.active) begin
         o_vector <= i_fast.vector;
         o_in_fast <= 1'b1;
      end else if (i_normal.active) begin
         o_vector <= i_normal.vector;
         o_in_fast <= 1'b0;
      end
   end
endmodule

// ===== bench/tb.sv
`timescale 1ns/100ps
module tb
   import prioritizer_pkg::*;
;
   logic i_clock;
   logic i_rst;
   logic [source_count-1:0] i_sources;
   cfg_cmd_type i_cfg;
   irq_req_type o_normal, o_fast, o_active;
   logic o_active_fast, o_read_valid, o_access_denied;
   logic [word_width-1:0] o_read_data;
   logic [index_width-1:0] core_vector;
   logic core_fast;
   int err_total, n_tests;

   vectored_interrupt_prioritizer dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_sources(i_sources), .i_cfg(i_cfg), .o_normal(o_normal), .o_fast(o_fast),
      .o_active(o_active), .o_active_fast(o_active_fast), .o_read_data(o_read_data),
      .o_read_valid(o_read_valid), .o_access_denied(o_access_denied));

   core_model core (.i_clock(i_clock), .i_rst(i_rst), .i_normal(o_normal),
      .i_fast(o_fast), .o_vector(core_vector), .o_in_fast(core_fast));

   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   // Bench always acts as the supervisor-mode master unless sup is cleared
   task cmd(input cfg_op_type op, input logic [5:0] idx, input logic [31:0] d,
            input logic sup);
      @(posedge i_clock);
      i_cfg <= '{1'b1, sup, op, idx, d};
      @(posedge i_clock);
      i_cfg <= '0;
   endtask

   task await(input logic deny);
      int k;
      k = 0;
      #1;
      while ((deny ? o_access_denied : o_read_valid) !== 1'b1) begin
         if (k == 4) begin
            err_total++;
            end_of_test;
         end
         @(posedge i_clock);
         #1;
         k++;
      end
   endtask

   task rd(input logic [5:0] sel, input logic [31:0] exp);
      cmd(op_read, sel, 32'h0, 1'b1);
      await(1'b0);
      chk({32'h0, o_read_data}, {32'h0, exp});
   endtask

   // Outputs are levels, so a few spare cycles past the sync delay are harmless
   task req(input irq_req_type n, input irq_req_type f);
      repeat (5) @(posedge i_clock);
      #1;
      chk({o_normal, o_fast, o_active, o_active_fast}, {n, f, (f.active ? f : n), f.active});
   endtask

   task src(input int n);
      @(posedge i_clock);
      i_sources[n] <= 1'b1;
   endtask

   function automatic irq_req_type q(input logic [5:0] v, input logic [3:0] l);
      return '{1'b1, v, l};
   endfunction

   initial begin
      repeat (20000) @(posedge i_clock);
      err_total++;
      end_of_test;
   end

   initial begin
      i_rst = 1'b1;
      i_sources = '0;
      i_cfg = '0;
      err_total = 0;
      n_tests = 0;
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(sel_mask, 32'h1f);
      rd(sel_enable_lo, 32'h0);
      rd(sel_type_hi, 32'h0);
      rd(sel_level_base + 6'h07, 32'h0);
      rd(6'h0f, 32'h0);
      req('0, '0);
      $display("test reset values done");
      cmd(op_enable_num, 6'h05, 32'h0, 1'b1);
      rd(sel_enable_lo, 32'h20);
      cmd(op_enable_hi, 6'h00, 32'h8000_0000, 1'b1);
      cmd(op_disable_num, 6'h05, 32'h0, 1'b1);
      rd(sel_enable_lo, 32'h0);
      rd(sel_enable_hi, 32'h8000_0000);
      $display("test enables done");
      cmd(op_enable_lo, 6'h00, 32'hffff_ffff, 1'b0);
      await(1'b1);
      cmd(op_read, sel_mask, 32'h0, 1'b0);
      await(1'b1);
      chk({63'h0, o_read_valid}, 64'h0);
      cmd(cfg_op_type'(4'hf), 6'h00, 32'hffff_ffff, 1'b1);
      rd(sel_enable_lo, 32'h0);
      $display("test user mode refusal done");
      cmd(op_level, 6'h00, 32'h3000_0000, 1'b1);
      cmd(op_level, 6'h02, 32'h0003_0000, 1'b1);
      cmd(op_enable_lo, 6'h00, 32'h0010_0080, 1'b1);
      rd(sel_level_base + 6'h02, 32'h0003_0000);
      src(7);
      req(q(6'h07, 4'h3), '0);
      src(20);
      req(q(6'h14, 4'h3), '0);
      src(63);
      req(q(6'h14, 4'h3), '0);
      cmd(op_level, 6'h07, 32'hf000_0000, 1'b1);
      req(q(6'h3f, 4'hf), '0);
      rd(sel_pending_hi, 32'h8000_0000);
      $display("test normal ranking done");
      cmd(op_mask, 6'h00, 32'h0000_000f, 1'b1);
      req('0, '0);
      cmd(op_mask, 6'h00, 32'h0000_000e, 1'b1);
      req(q(6'h3f, 4'hf), '0);
      $display("test mask done");
      cmd(op_type_lo, 6'h00, 32'h0000_0080, 1'b1);
      req(q(6'h3f, 4'hf), q(6'h07, 4'h0));
      chk({57'h0, core_fast, core_vector}, {57'h0, 1'b1, 6'h07});
      cmd(op_mask, 6'h00, 32'h0000_000f, 1'b1);
      req('0, q(6'h07, 4'h0));
      rd(sel_type_lo, 32'h0000_0080);
      cmd(op_type_hi, 6'h00, 32'h8000_0000, 1'b1);
      req('0, q(6'h3f, 4'h0));
      rd(sel_type_hi, 32'h8000_0000);
      $display("test fast requests done");
      @(posedge i_clock);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      rd(sel_enable_hi, 32'h0);
      rd(sel_mask, 32'h1f);
      req('0, '0);
      chk({57'h0, core_fast, core_vector}, 64'h0);
      $display("test mid-run reset done");
      end_of_test;
   end
endmodule
